//--- rtl/sfs_front_end.v
// Serial flash front end: chip-select framing, bit shifting, hold and write protect
// What this block does
// - Accept serial input only while select low
// - Deselect means standby and released serial output
// - Operations framed by select fall and rise
// - Standby waits for internal cycle to finish
// - Sample serial input on clock rising edges
// - Change serial output only on falling edges
// - Same edge roles for idle-low and idle-high clock
// - Hold freezes shifting and releases output
// - Hold starts only selected with clock low
// - Hold leaves internal cycles running
// - Write-protect low locks protected regions
// - Write-protect and hold default to released
// - Eight-bit opcode first, all bytes MSB first
// - Unknown opcode ignored until next selection
// - Early deselect performs nothing, back to idle
`timescale 1ns/1ps
`include "sfs_regs.vh"
module sfs_front_end (
  input  wire        clk,          // System clock, 40 MHz
  input  wire        rst,          // Async reset, active high
  input  wire        cs_n_pin,     // Chip select pin, active low
  input  wire        sck_pin,      // Serial clock pin
  input  wire        si_pin,       // Serial data in pin
  input  wire        hold_n_pin,   // Hold pin, active low
  input  wire        wp_n_pin,     // Write-protect pin, active low
  output reg         so_o,         // Serial data out level
  output reg         so_oe,        // Serial data out enable, high drives
  input  wire        busy_i,       // Internal program/erase cycle running
  input  wire [7:0]  rd_data_i,    // Next byte to send for reads
  output reg         cmd_start_o,  // Pulse: opcode and header complete
  output reg  [7:0]  opcode_o,     // Opcode of current operation
  output reg  [23:0] addr_o,       // Address of current operation
  output reg         wr_valid_o,   // Pulse: one write byte received
  output reg  [7:0]  wr_data_o,    // Received write byte
  output reg         rd_req_o,     // Pulse: next read byte wanted
  output reg         op_done_o,    // Pulse: deselect ended a started operation
  output reg         op_abort_o,   // Pulse: deselect ended an incomplete operation
  output reg         standby_o,    // Deselected and no internal cycle
  output reg         wp_lock_o,    // Protected regions locked
  output reg         hold_o,       // Hold condition active
  output reg         selected_o    // Operation in progress
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_DONE  = 3'h6;
  localparam [2:0] ST_IGN   = 3'h7;

  wire [4:0] pin_s;
  wire       cs_n_s;
  wire       sck_s;
  wire       si_s;
  wire       hold_n_s;
  wire       wp_n_s;

  reg        cs_prev_q;
  reg        sck_prev_q;
  reg        hold_q;
  reg  [2:0] st_q;
  reg  [2:0] bit_q;
  reg  [1:0] cnt_q;
  reg  [6:0] in_sh_q;
  reg  [6:0] dec_q;
  reg  [6:0] out_sh_q;
  reg  [2:0] out_bit_q;
  reg        drive_q;

  wire       cs_fall;
  wire       cs_rise;
  wire       sck_rise;
  wire       sck_fall;
  wire [7:0] in_byte;
  wire       byte_end;
  wire [6:0] dec_now;

  // Pins cross into the clock domain; synchroniser reset levels make wp and hold reset released
  sfs_sync #(
    .W   (`SFS_PIN_W),
    .RST (`SFS_PIN_RST)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({wp_n_pin, hold_n_pin, si_pin, sck_pin, cs_n_pin}),
    .q   (pin_s)
  );

  assign cs_n_s   = pin_s[0];
  assign sck_s    = pin_s[1];
  assign si_s     = pin_s[2];
  assign hold_n_s = pin_s[3];
  assign wp_n_s   = pin_s[4];

  // Edges of select and of the serial clock; clock idle level does not matter
  assign cs_fall  = cs_prev_q & ~cs_n_s;
  assign cs_rise  = ~cs_prev_q & cs_n_s;
  assign sck_rise = ~sck_prev_q & sck_s & ~cs_n_s & ~hold_q;
  assign sck_fall = sck_prev_q & ~sck_s & ~cs_n_s & ~hold_q;
  assign in_byte  = {in_sh_q, si_s};
  assign byte_end = (bit_q == 3'h7);
  assign dec_now  = sfs_decode(in_byte);

  // Opcode table: {known, address bytes, dummy bytes, data kind}
  function [6:0] sfs_decode;
    input [7:0] op;
    begin
      case (op)
        `SFS_OP_RD_FAST:   sfs_decode = {1'b1, 2'h3, 2'h1, `SFS_KIND_READ};
        `SFS_OP_RD_SLOW:   sfs_decode = {1'b1, 2'h3, 2'h0, `SFS_KIND_READ};
        `SFS_OP_ER_4K,
        `SFS_OP_ER_32K_A,
        `SFS_OP_ER_32K_B:  sfs_decode = {1'b1, 2'h3, 2'h0, `SFS_KIND_NONE};
        `SFS_OP_ER_CHIP_A,
        `SFS_OP_ER_CHIP_B,
        `SFS_OP_ER_CHIP_C,
        `SFS_OP_WR_EN,
        `SFS_OP_WR_DIS:    sfs_decode = {1'b1, 2'h0, 2'h0, `SFS_KIND_NONE};
        `SFS_OP_PROG,
        `SFS_OP_OTP_PROG:  sfs_decode = {1'b1, 2'h3, 2'h0, `SFS_KIND_WRITE};
        `SFS_OP_OTP_RD:    sfs_decode = {1'b1, 2'h3, 2'h2, `SFS_KIND_READ};
        `SFS_OP_STAT_RD:   sfs_decode = {1'b1, 2'h0, 2'h0, `SFS_KIND_READ};
        `SFS_OP_STAT_WR:   sfs_decode = {1'b1, 2'h0, 2'h0, `SFS_KIND_WRITE};
        default:           sfs_decode = 7'h00;
      endcase
    end
  endfunction

  // Body state after the header, chosen by the data kind
  function [2:0] sfs_body;
    input [1:0] kind;
    begin
      case (kind)
        `SFS_KIND_READ:  sfs_body = ST_RDATA;
        `SFS_KIND_WRITE: sfs_body = ST_WDATA;
        default:         sfs_body = ST_DONE;
      endcase
    end
  endfunction

  // Edge history and hold tracking
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
      hold_q     <= 1'b0;
    end else begin
      cs_prev_q  <= cs_n_s;
      sck_prev_q <= sck_s; // Tracks during hold so release gives no false edge
      if (cs_n_s) begin
        hold_q <= 1'b0;
      end else if (hold_q) begin
        hold_q <= ~hold_n_s;
      end else if (~hold_n_s && ~sck_s) begin
        hold_q <= 1'b1;
      end
    end
  end

  // Framing and input shifting; hold only gates the edges, never the state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      bit_q       <= 3'h0;
      cnt_q       <= 2'h0;
      in_sh_q     <= 7'h00;
      dec_q       <= 7'h00;
      opcode_o    <= 8'h00;
      addr_o      <= 24'h000000;
      cmd_start_o <= 1'b0;
      wr_valid_o  <= 1'b0;
      wr_data_o   <= 8'h00;
      op_done_o   <= 1'b0;
      op_abort_o  <= 1'b0;
    end else begin
      cmd_start_o <= 1'b0;
      wr_valid_o  <= 1'b0;
      op_done_o   <= 1'b0;
      op_abort_o  <= 1'b0;
      if (cs_n_s) begin
        // Deselect ends everything; only completed headers count as work
        if (cs_rise && st_q != ST_IDLE) begin
          if (st_q == ST_WDATA || st_q == ST_RDATA || st_q == ST_DONE) begin
            op_done_o <= 1'b1;
          end else begin
            op_abort_o <= 1'b1;
          end
        end
        st_q  <= ST_IDLE;
        bit_q <= 3'h0;
      end else if (st_q == ST_IDLE) begin
        // A select already low at reset release still starts an operation, as the synchroniser resets to deselected
        if (cs_fall) begin
          st_q  <= ST_OPC;
          bit_q <= 3'h0;
        end
      end else if (sck_rise) begin
        in_sh_q <= in_byte[6:0];
        bit_q   <= bit_q + 3'h1;
        if (byte_end) begin
          case (st_q)
            ST_OPC: begin
              opcode_o <= in_byte;
              dec_q    <= dec_now;
              if (!dec_now[`SFS_DEC_KNOWN]) begin
                st_q <= ST_IGN;
              end else if (dec_now[`SFS_DEC_ADDR_HI:`SFS_DEC_ADDR_LO] != 2'h0) begin
                st_q  <= ST_ADDR;
                cnt_q <= dec_now[`SFS_DEC_ADDR_HI:`SFS_DEC_ADDR_LO] - 2'h1;
              end else if (dec_now[`SFS_DEC_DUMMY_HI:`SFS_DEC_DUMMY_LO] != 2'h0) begin
                st_q  <= ST_DUMMY;
                cnt_q <= dec_now[`SFS_DEC_DUMMY_HI:`SFS_DEC_DUMMY_LO] - 2'h1;
              end else begin
                st_q        <= sfs_body(dec_now[`SFS_DEC_KIND_HI:`SFS_DEC_KIND_LO]);
                cmd_start_o <= 1'b1;
              end
            end
            ST_ADDR: begin
              addr_o <= {addr_o[15:0], in_byte};
              cnt_q  <= cnt_q - 2'h1;
              if (cnt_q == 2'h0) begin
                if (dec_q[`SFS_DEC_DUMMY_HI:`SFS_DEC_DUMMY_LO] != 2'h0) begin
                  st_q  <= ST_DUMMY;
                  cnt_q <= dec_q[`SFS_DEC_DUMMY_HI:`SFS_DEC_DUMMY_LO] - 2'h1;
                end else begin
                  st_q        <= sfs_body(dec_q[`SFS_DEC_KIND_HI:`SFS_DEC_KIND_LO]);
                  cmd_start_o <= 1'b1;
                end
              end
            end
            ST_DUMMY: begin
              cnt_q <= cnt_q - 2'h1;
              if (cnt_q == 2'h0) begin
                st_q        <= sfs_body(dec_q[`SFS_DEC_KIND_HI:`SFS_DEC_KIND_LO]);
                cmd_start_o <= 1'b1;
              end
            end
            ST_WDATA: begin
              wr_valid_o <= 1'b1;
              wr_data_o  <= in_byte;
            end
            default: begin
              st_q <= st_q; // Read, done and ignore states discard input
            end
          endcase
        end
      end
    end
  end

  // Output shifting: bytes load and bits move only on falling edges
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      so_o      <= 1'b0;
      out_sh_q  <= 7'h00;
      out_bit_q <= 3'h0;
      drive_q   <= 1'b0;
      rd_req_o  <= 1'b0;
    end else begin
      rd_req_o <= 1'b0;
      if (st_q != ST_RDATA) begin
        drive_q   <= 1'b0;
        out_bit_q <= 3'h0;
      end else if (sck_fall) begin
        drive_q   <= 1'b1;
        out_bit_q <= out_bit_q + 3'h1;
        if (out_bit_q == 3'h0) begin
          so_o     <= rd_data_i[7];
          out_sh_q <= rd_data_i[6:0];
          rd_req_o <= 1'b1;
        end else begin
          so_o     <= out_sh_q[6];
          out_sh_q <= {out_sh_q[5:0], 1'b0};
        end
      end
      // First byte is requested as soon as the header completes
      if (cmd_start_o && st_q == ST_RDATA) begin
        rd_req_o <= 1'b1;
      end
    end
  end

  // Status levels; the enable falls at once on deselect or hold
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      so_oe      <= 1'b0;
      standby_o  <= 1'b1;
      wp_lock_o  <= 1'b0;
      hold_o     <= 1'b0;
      selected_o <= 1'b0;
    end else begin
      so_oe      <= drive_q & (st_q == ST_RDATA) & ~cs_n_s & ~hold_q;
      standby_o  <= cs_n_s & ~busy_i;
      wp_lock_o  <= ~wp_n_s;
      hold_o     <= hold_q;
      selected_o <= (st_q != ST_IDLE) & ~cs_n_s;
    end
  end

endmodule

//--- rtl/sfs_regs.vh
// Constants for the serial flash front end: pin reset levels and opcode table
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

// Synchroniser reset levels, {wp_n, hold_n, si, sck, cs_n}: deselected, hold and wp released
`define SFS_PIN_RST      5'h19
`define SFS_PIN_W        5

// Field positions inside a decoded opcode entry
`define SFS_DEC_W        7
`define SFS_DEC_KNOWN    6
`define SFS_DEC_ADDR_HI  5
`define SFS_DEC_ADDR_LO  4
`define SFS_DEC_DUMMY_HI 3
`define SFS_DEC_DUMMY_LO 2
`define SFS_DEC_KIND_HI  1
`define SFS_DEC_KIND_LO  0

// Data phase kinds
`define SFS_KIND_NONE    2'h0
`define SFS_KIND_WRITE   2'h1
`define SFS_KIND_READ    2'h2

// Supported opcodes
`define SFS_OP_RD_FAST   8'h0b
`define SFS_OP_RD_SLOW   8'h03
`define SFS_OP_ER_4K     8'h20
`define SFS_OP_ER_32K_A  8'h52
`define SFS_OP_ER_32K_B  8'hd8
`define SFS_OP_ER_CHIP_A 8'h60
`define SFS_OP_ER_CHIP_B 8'hc7
`define SFS_OP_ER_CHIP_C 8'h62
`define SFS_OP_PROG      8'h02
`define SFS_OP_WR_EN     8'h06
`define SFS_OP_WR_DIS    8'h04
`define SFS_OP_OTP_PROG  8'h9b
`define SFS_OP_OTP_RD    8'h77
`define SFS_OP_STAT_RD   8'h05
`define SFS_OP_STAT_WR   8'h01

`endif

//--- rtl/sfs_sync.v
// Two-flop synchroniser bank for the serial pins
`timescale 1ns/1ps
module sfs_sync #(
  parameter             W   = 1,
  parameter [W-1:0]     RST = {W{1'b0}}
) (
  input  wire         clk,   // Sampling clock
  input  wire         rst,   // Async reset, active high
  input  wire [W-1:0] d,     // Asynchronous pin levels
  output wire [W-1:0] q      // Synchronised levels
);

  genvar i;

  // One pair of flops per pin; stage one feeds only stage two
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q <= RST[i];
          s2_q <= RST[i];
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
        end
      end
      assign q[i] = s2_q;
    end
  endgenerate

endmodule

//--- tb/sfs_front_end_monitor.sv
// Port assertions for the serial flash front end
`timescale 1ns/1ps
module sfs_mon (
  input wire clk,         // Clock
  input wire rst,         // Reset
  input wire cs_n_pin,    // Select
  input wire wp_n_pin,    // Protect
  input wire so_oe,       // Out enable
  input wire busy_i,      // Busy
  input wire cmd_start_o, // Start
  input wire op_done_o,   // Done
  input wire op_abort_o,  // Abort
  input wire standby_o,   // Standby
  input wire wp_lock_o,   // Lock
  input wire hold_o,      // Hold
  input wire selected_o   // Selected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Six clocks covers the pin synchroniser and the registered outputs
  sequence s_idle; cs_n_pin [*6]; endsequence
  sequence s_held; hold_o [*2]; endsequence
  property p_idle; s_idle |-> !so_oe && !selected_o; endproperty
  a_idle: assert property (p_idle) else $error("active while deselected");
  property p_busy; busy_i |=> !standby_o; endproperty
  a_busy: assert property (p_busy) else $error("standby while busy");
  property p_hold; s_held |-> !so_oe; endproperty
  a_hold: assert property (p_hold) else $error("output driven in hold");
  property p_hsel; $rose(hold_o) |-> selected_o && !cs_n_pin; endproperty
  a_hsel: assert property (p_hsel) else $error("hold outside selection");
  property p_lock; !wp_n_pin [*4] |-> wp_lock_o; endproperty
  a_lock: assert property (p_lock) else $error("lock missing");
  property p_free; wp_n_pin [*4] |-> !wp_lock_o; endproperty
  a_free: assert property (p_free) else $error("lock while released");
  property p_end; op_done_o || op_abort_o |-> !selected_o && !(op_done_o && op_abort_o);
  endproperty
  a_end: assert property (p_end) else $error("bad end pulse");
  property p_start; cmd_start_o |-> selected_o && !so_oe; endproperty
  a_start: assert property (p_start) else $error("bad header end");
endmodule
bind sfs_front_end sfs_mon u_mon (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin),
  .wp_n_pin(wp_n_pin), .so_oe(so_oe), .busy_i(busy_i), .cmd_start_o(cmd_start_o),
  .op_done_o(op_done_o), .op_abort_o(op_abort_o), .standby_o(standby_o),
  .wp_lock_o(wp_lock_o), .hold_o(hold_o), .selected_o(selected_o));

//--- tb/sfs_host.sv
// Host model driving the serial pins in mode 0 or 3
`timescale 1ns/1ps
module sfs_host (
  input  wire clk,    // Bench clock
  input  wire so_w,   // Serial out wire
  output reg  cs_n,   // Select, active low
  output reg  sck,    // Link clock
  output reg  si,     // Serial in
  output reg  hold_n  // Hold, active low
);
  reg mode3; // Clock idles high when set
  // Pins start idle: deselected, clock low, hold released
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    mode3 = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Clock parked at idle before the select edge
  task sel;
    sck <= mode3;
    wt(4);
    cs_n <= 1'b0;
    wt(4);
  endtask
  task desel;
    wt(4);
    sck <= mode3;
    wt(4);
    cs_n <= 1'b1;
    si <= ~si; // Released line must not look stable
    wt(12);
  endtask
  // Each bit opens by driving the clock low, a falling edge unless it is already low, so mode 3 ends high with no spare edge;
  // the read bit is taken late in the high phase, long after the device moved it
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      sck <= 1'b0;
      si <= tx[i];
      wt(4);
      sck <= 1'b1;
      wt(3);
      rx[i] = so_w;
      wt(1);
    end
  endtask
  // Junk clock pulses
  task wig;
    repeat (4) begin
      si <= ~si;
      sck <= 1'b1;
      wt(4);
      sck <= 1'b0;
      wt(4);
    end
  endtask
  // Only called while selected; the clock is brought low first so hold may start
  task hold(input v);
    sck <= 1'b0;
    wt(4);
    hold_n <= v;
    wt(8);
  endtask
endmodule

//--- tb/tb_sfs_front_end.sv
// Bench for the serial flash front end
`timescale 1ns/1ps
module tb_sfs_front_end;
  reg         clk;
  reg         rst;
  reg         wp_n;
  reg         busy;
  reg  [7:0]  rd;
  reg  [7:0]  rx;
  integer     miscompares = 0, checks = 0, cyc = 0, st, dn, ab, wr, rq, oe;
  wire        cs_n, sck, si, hold_n, so_o, so_oe, cmd, wv, rreq, done, abt, stb, lck, hld, sel;
  wire [7:0]  op, wd;
  wire [23:0] addr;
  wire        so_w = so_oe ? so_o : 1'bz;
  sfs_front_end dut (.clk(clk), .rst(rst), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
    .hold_n_pin(hold_n), .wp_n_pin(wp_n), .so_o(so_o), .so_oe(so_oe), .busy_i(busy),
    .rd_data_i(rd), .cmd_start_o(cmd), .opcode_o(op), .addr_o(addr), .wr_valid_o(wv),
    .wr_data_o(wd), .rd_req_o(rreq), .op_done_o(done), .op_abort_o(abt), .standby_o(stb),
    .wp_lock_o(lck), .hold_o(hld), .selected_o(sel));
  sfs_host host (.clk(clk), .so_w(so_w), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  always #12.5 clk = ~clk;
  // Pulse tallies, timeout, and a back end giving a fresh byte per request
  always @(posedge clk) begin
    cyc <= cyc + 1;
    st <= st + cmd;
    dn <= dn + done;
    ab <= ab + abt;
    wr <= wr + wv;
    oe <= oe | so_oe;
    if (rreq === 1'b1) begin
      rd <= 8'hc3 ^ rq[7:0];
      rq <= rq + 1;
    end
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cleared off the sampling edge so the tallies do not race
  task clr;
    @(negedge clk);
    {st, dn, ab, wr, rq, oe} = 0;
  endtask
  task send(input [31:0] w, input integer n);
    integer i;
    for (i = n - 1; i >= 0; i = i - 1)
      host.xfer(w[8*i +: 8], rx);
  endtask
  task t_read;
    clr;
    host.sel;
    send(32'h03123456, 4);
    chk(oe, 0);
    send(32'h0, 1);
    chk(rx, 8'hc3);
    send(32'h0, 1);
    chk(rx, 8'hc2);
    host.desel;
    chk({op, addr}, 32'h03123456);
    chk(st * 16 + dn, 17);
  endtask
  task t_prog;
    clr;
    host.mode3 = 1'b1;
    host.sel;
    send(32'h020001ff, 4);
    send(32'ha53c, 2);
    host.desel;
    host.mode3 = 1'b0;
    chk({op, addr}, 32'h020001ff);
    chk({wd, wr[3:0], oe[3:0]}, 16'h3c20);
  endtask
  // Early deselect, then an unknown opcode trailed by a valid one
  task t_abort;
    clr;
    host.sel;
    send(32'h0312, 2);
    host.desel;
    host.sel;
    send(32'hff020000, 4);
    host.desel;
    chk(ab * 16 + st, 32);
  endtask
  task t_hold;
    clr;
    host.sel;
    send(32'h0bab, 2);
    host.hold(1'b0);
    host.wig;
    chk({hld, so_oe, sel}, 3'b101);
    host.hold(1'b1);
    send(32'hcdef00, 3);
    send(32'h0, 1);
    chk(rx, 8'hc3);
    // Pause between read data bytes: output lets go, then resumes with the next byte
    host.hold(1'b0);
    host.wig;
    chk({hld, so_oe, sel}, 3'b101);
    host.hold(1'b1);
    send(32'h0, 1);
    chk(rx, 8'hc2);
    host.desel;
    chk({addr, st[3:0]}, 28'habcdef1);
  endtask
  // Noise while deselected, erase ending in an internal cycle, protect pin
  task t_busy;
    clr;
    host.wig;
    chk(sel + st + ab, 0);
    busy <= 1'b1;
    host.sel;
    send(32'h60, 1);
    host.desel;
    chk(stb, 0);
    busy <= 1'b0;
    wp_n <= 1'b0;
    host.wt(5);
    chk(stb + dn + lck, 3);
    wp_n <= 1'b1;
    host.wt(5);
    chk(lck, 0);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp_n = 1'b1;
    busy = 1'b0;
    rd = 8'h00;
    clr;
    host.wt(5);
    rst <= 1'b0;
    host.wt(4);
    t_read;
    t_prog;
    t_abort;
    t_hold;
    t_busy;
    end_of_test;
  end
endmodule
